// ===== rtl/pst_bank.sv
// Status and telemetry command bank of a two-channel regulator controller
//
// Contract
// - Other-status bit 0 latches first_alerter_flag; bits 7:1 read zero.
// - Other-status is shared; summary byte per page ORs shared bits.
// - A raised shared condition updates both page summary copies together.
// - Write-one clear of shared bit clears matching summary bit both pages.
// - Vendor status at 80h per page; clear-faults or write-one clears.
// - Vendor bit 7 sets on self-check failure; device stays latched off.
// - Vendor bit 6 sets when extended detail has been recorded.
// - Vendor bit 5 latches when output settled at new target.
// - Vendor bit 4 sets when a per-phase error is recorded.
// - Bit 3 latches on reset pin event; stays 0 if unassigned.
// - Vendor bit 0 latches on power stage fault for its page.
// - Each alerting status bit has a mask bit blocking alert.
// - Input voltage at 88h unpaged, exponent 15:11, mantissa 10:0.
// - Input current at 89h; calculated option imputes via gain factor.
// - Write to read-only telemetry sets summary CML, comm fault, alert.
// - Output voltage at 8Bh; page 00h/FFh channel A, 01h B.
// - Output current at 8Ch paged and phased by channel.
// - Phase FFh returns total controller current for selected page.
// - Phase 00h-07h returns current of its mapped power stage; 08h-FEh read zero.
// - Temperature at 8Dh paged, exponent LSB one degree Celsius.
// - Temperature page 00h/FFh channel A sense, 01h channel B.
// - 8Eh is a shadow returning same temperature data.
// - Communications status bit 0 flags write to read-only command.
`timescale 1ns/100ps
module pst_bank
	import pst_pkg::*;
(
	input wire logic clk,
	input wire logic rstn,
	// Command port from the protocol engine
	input wire logic cmd_valid,
	input wire logic cmd_write,
	input wire logic [7:0] cmd_code,
	input wire logic [7:0] cmd_wdata,
	input wire logic clear_all_faults_cmd,
	input wire logic [7:0] page_sel,
	input wire logic [7:0] phase_sel,
	output logic rsp_valid,
	output logic [15:0] rsp_data,
	output logic rsp_hit,
	// Status sources
	input wire logic alert_first_evt,
	input wire logic selfcheck_fail,
	input wire logic [1:0] extended_info_evt,
	input wire logic [1:0] output_settled_evt,
	input wire logic [1:0] phase_error_evt,
	input wire logic reset_pin_assigned,
	input wire logic reset_pin_evt,
	input wire logic [1:0] stage_fault_indication,
	input wire logic [7:0] alert_mask_other,
	input wire logic [7:0] alert_mask_vendor,
	input wire logic alert_mask_cml,
	// Telemetry samples
	input wire logic sample_strobe,
	input wire logic [15:0] vin_sample,
	input wire logic [15:0] iin_sample,
	input wire logic [15:0] iin_calc_base,
	input wire logic calculated_input_current_select,
	input wire logic [15:0] calibration_gain_config,
	input wire logic [15:0] vout_a_sample,
	input wire logic [15:0] vout_b_sample,
	input wire logic [15:0] iout_a_total,
	input wire logic [15:0] iout_b_total,
	input wire logic [PHASE_NUM*16-1:0] stage_current,
	input wire logic [PHASE_NUM*3-1:0] phase_stage_map,
	input wire logic [15:0] chan_a_temp_sense,
	input wire logic [15:0] chan_b_temp_sense,
	// Status outputs
	output logic [7:0] other_status_byte,
	output logic [7:0] vendor_status_a,
	output logic [7:0] vendor_status_b,
	output logic [7:0] summary_a,
	output logic [7:0] summary_b,
	output logic other_comm_fault_flag,
	output logic latched_off,
	output logic alert_out
);
	import pst_pkg::*;

	// ------------------------------------------------------------
	// Helpers
	// ------------------------------------------------------------
	function automatic logic page_is_b(input logic [7:0] pg);
		page_is_b = (pg == PAGE_B);
	endfunction

	// Page 00h and FFh both mean channel A; only 01h picks B
	function automatic logic [15:0] by_page(input logic b,
		input logic [15:0] wa, input logic [15:0] wb);
		by_page = b ? wb : wa;
	endfunction

	function automatic logic [7:0] w1c(input logic [7:0] cur,
		input logic [7:0] set, input logic [7:0] clr,
		input logic [7:0] mask);
		// Set wins over a clear in the same cycle
		w1c = ((cur & ~clr) | set) & mask;
	endfunction

	// ------------------------------------------------------------
	// Command decode
	// ------------------------------------------------------------
	wire logic wr = cmd_valid & cmd_write;
	wire logic rd = cmd_valid & ~cmd_write;
	wire logic sel_b = page_is_b(page_sel);
	wire logic wr_other = wr & (cmd_code == CMD_OTHER_STATUS);
	wire logic wr_vendor = wr & (cmd_code == CMD_VENDOR_STATUS);
	wire logic hit_vin = (cmd_code == CMD_VIN);
	wire logic hit_iin = (cmd_code == CMD_IIN);
	wire logic hit_vout = (cmd_code == CMD_VOUT);
	wire logic hit_iout = (cmd_code == CMD_IOUT);
	wire logic hit_temp1 = (cmd_code == CMD_TEMP1);
	wire logic hit_temp2 = (cmd_code == CMD_TEMP2);
	// Every telemetry code is read-only, so any write to one is a fault
	wire logic is_telem = hit_vin | hit_iin | hit_vout | hit_iout |
		hit_temp1 | hit_temp2;
	wire logic wr_ro = wr & is_telem;
	// Write to page FFh addresses both channels
	wire logic wr_all = (page_sel == PAGE_ALL);
	wire logic wr_a_pg = wr_vendor & (~sel_b | wr_all);
	wire logic wr_b_pg = wr_vendor & (sel_b | wr_all);

	// ------------------------------------------------------------
	// Status latches
	// ------------------------------------------------------------
	logic [7:0] other_r;
	logic [7:0] vend_a_r;
	logic [7:0] vend_b_r;
	logic cml_r;
	logic off_r;

	wire logic [7:0] other_set =
		{7'b0, alert_first_evt} << FIRST_ALERTER_BIT;
	wire logic [7:0] other_clr = clear_all_faults_cmd ? 8'hFF :
		(wr_other ? cmd_wdata : 8'h00);
	wire logic [7:0] other_nxt =
		w1c(other_r, other_set, other_clr, OTHER_MASK);

	// ------------------------------------------------------------
	// Vendor status latches
	// ------------------------------------------------------------
	// All sources come in as arguments: a continuous assignment wakes up
	// only when an argument changes, never on a signal read inside
	function automatic logic [7:0] vend_set(input logic por,
		input logic extended_info_flag, input logic settled, input logic ph,
		input logic rpin, input logic flt);
		logic [7:0] v;
		v = 8'h00;
		v[SELFCHECK_BIT] = por;
		v[EXT_INFO_BIT] = extended_info_flag;
		v[SETTLED_BIT] = settled;
		v[PHASE_ERR_BIT] = ph;
		v[RESET_PIN_BIT] = rpin;
		v[STAGE_FAULT_BIT] = flt;
		vend_set = v;
	endfunction

	// A reset pin event only counts when a pin carries that function
	wire logic rpin_evt = reset_pin_evt & reset_pin_assigned;
	wire logic [7:0] rst_keep =
		reset_pin_assigned ? 8'hFF : ~(8'h01 << RESET_PIN_BIT);
	wire logic [7:0] va_set = vend_set(selfcheck_fail,
		extended_info_evt[0], output_settled_evt[0], phase_error_evt[0],
		rpin_evt, stage_fault_indication[0]);
	wire logic [7:0] vb_set = vend_set(selfcheck_fail,
		extended_info_evt[1], output_settled_evt[1], phase_error_evt[1],
		rpin_evt, stage_fault_indication[1]);
	wire logic [7:0] va_clr = clear_all_faults_cmd ? 8'hFF :
		(wr_a_pg ? cmd_wdata : 8'h00);
	wire logic [7:0] vb_clr = clear_all_faults_cmd ? 8'hFF :
		(wr_b_pg ? cmd_wdata : 8'h00);
	wire logic [7:0] va_nxt =
		w1c(vend_a_r, va_set, va_clr, VENDOR_MASK & rst_keep);
	wire logic [7:0] vb_nxt =
		w1c(vend_b_r, vb_set, vb_clr, VENDOR_MASK & rst_keep);
	wire logic cml_nxt = wr_ro | (cml_r & ~clear_all_faults_cmd);

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			vend_a_r <= STATUS_RESET;
			vend_b_r <= STATUS_RESET;
		end else begin
			vend_a_r <= va_nxt;
			vend_b_r <= vb_nxt;
		end
	end

	// Shared bytes and the shutdown latch are common to both pages
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			other_r <= STATUS_RESET;
			cml_r <= 1'b0;
			off_r <= 1'b0;
		end else begin
			other_r <= other_nxt;
			cml_r <= cml_nxt;
			// Self-check failure latches off until power cycle
			off_r <= off_r | selfcheck_fail;
		end
	end

	// ------------------------------------------------------------
	// Summary bytes and alert
	// ------------------------------------------------------------
	// Shared bits feed both copies from one source, so they move together
	function automatic logic [7:0] summary(input logic [7:0] oth,
		input logic cml, input logic [7:0] vend);
		logic [7:0] s;
		s = 8'h00;
		s[SUM_OTHER_BIT] = |(oth & OTHER_MASK);
		s[SUM_VENDOR_BIT] = |vend;
		s[SUM_CML_BIT] = cml;
		summary = s;
	endfunction

	wire logic [7:0] sum_a_nxt = summary(other_nxt, cml_nxt, va_nxt);
	wire logic [7:0] sum_b_nxt = summary(other_nxt, cml_nxt, vb_nxt);

	// Each source is gated by a mask before the OR; vendor A and B share alert_mask_vendor
	wire logic alert_other = |(other_nxt & ~alert_mask_other);
	wire logic alert_vend_a = |(va_nxt & ~alert_mask_vendor);
	wire logic alert_vend_b = |(vb_nxt & ~alert_mask_vendor);
	wire logic alert_cml = cml_nxt & ~alert_mask_cml;
	wire logic alert_nxt =
		alert_other | alert_vend_a | alert_vend_b | alert_cml;

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			other_status_byte <= STATUS_RESET;
			vendor_status_a <= STATUS_RESET;
			vendor_status_b <= STATUS_RESET;
			summary_a <= STATUS_RESET;
			summary_b <= STATUS_RESET;
			other_comm_fault_flag <= 1'b0;
		end else begin
			other_status_byte <= other_nxt;
			vendor_status_a <= va_nxt;
			vendor_status_b <= vb_nxt;
			summary_a <= sum_a_nxt;
			summary_b <= sum_b_nxt;
			other_comm_fault_flag <= cml_nxt;
		end
	end

	// Alert and shutdown kept apart from the status bytes they summarise
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			latched_off <= 1'b0;
			alert_out <= 1'b0;
		end else begin
			latched_off <= off_r | selfcheck_fail;
			alert_out <= alert_nxt;
		end
	end

	// ------------------------------------------------------------
	// Telemetry sample holding
	// ------------------------------------------------------------
	logic [15:0] vin_r;
	logic [15:0] iin_r;
	logic [15:0] vout_a_r;
	logic [15:0] vout_b_r;
	logic [15:0] iout_a_r;
	logic [15:0] iout_b_r;
	logic [15:0] temp_a_r;
	logic [15:0] temp_b_r;
	logic [15:0] stage_r [PHASE_NUM];

	// Imputed current: mantissa scaled by gain, exponent kept
	// Product bits above the kept 11 are dropped, so a large gain wraps
	wire logic [26:0] calc_prod =
		27'(iin_calc_base[10:0]) * 27'(calibration_gain_config);
	wire logic [15:0] iin_calc =
		{iin_calc_base[15:11], calc_prod[GAIN_SHIFT +: 11]};
	wire logic [15:0] iin_pick =
		calculated_input_current_select ? iin_calc : iin_sample;

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			vin_r <= WORD_RESET;
			iin_r <= WORD_RESET;
			vout_a_r <= WORD_RESET;
			vout_b_r <= WORD_RESET;
			iout_a_r <= WORD_RESET;
			iout_b_r <= WORD_RESET;
			temp_a_r <= WORD_RESET;
			temp_b_r <= WORD_RESET;
		end else if (sample_strobe) begin
			// Whole set captured at once: a read sees one coherent sample
			vin_r <= vin_sample;
			iin_r <= iin_pick;
			vout_a_r <= vout_a_sample;
			vout_b_r <= vout_b_sample;
			iout_a_r <= iout_a_total;
			iout_b_r <= iout_b_total;
			temp_a_r <= chan_a_temp_sense;
			temp_b_r <= chan_b_temp_sense;
		end
	end

	// Stage currents held as words, one per power stage, same strobe
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			for (int k = 0; k < PHASE_NUM; k++) begin
				stage_r[k] <= WORD_RESET;
			end
		end else if (sample_strobe) begin
			for (int k = 0; k < PHASE_NUM; k++) begin
				stage_r[k] <= stage_current[k*16 +: 16];
			end
		end
	end

	// ------------------------------------------------------------
	// Read mux
	// ------------------------------------------------------------
	wire logic [2:0] phase_idx = 3'(phase_sel);
	wire logic phase_ok = (phase_sel < 8'(PHASE_NUM));
	wire logic [2:0] stage_idx = phase_stage_map[phase_idx*3 +: 3];
	wire logic [15:0] stage_word =
		phase_ok ? stage_r[stage_idx] : WORD_RESET;
	wire logic [15:0] iout_total =
		by_page(sel_b, iout_a_r, iout_b_r);
	wire logic [15:0] iout_word =
		(phase_sel == PHASE_ALL) ? iout_total : stage_word;
	wire logic [15:0] temp_word =
		by_page(sel_b, temp_a_r, temp_b_r);
	wire logic [15:0] vout_word =
		by_page(sel_b, vout_a_r, vout_b_r);
	wire logic [7:0] vend_word = sel_b ? vend_b_r : vend_a_r;
	// Byte commands answer in the low byte, high byte zero
	wire logic [15:0] other_word = {8'h00, other_r};
	wire logic [15:0] vend_half = {8'h00, vend_word};

	logic [15:0] rd_word;
	logic rd_hit;
	always_comb begin
		rd_word = WORD_RESET;
		rd_hit = 1'b1;
		case (cmd_code)
			CMD_OTHER_STATUS: rd_word = other_word;
			CMD_VENDOR_STATUS: rd_word = vend_half;
			CMD_VIN: rd_word = vin_r;
			CMD_IIN: rd_word = iin_r;
			CMD_VOUT: rd_word = vout_word;
			CMD_IOUT: rd_word = iout_word;
			CMD_TEMP1: rd_word = temp_word;
			CMD_TEMP2: rd_word = temp_word;
			default: rd_hit = 1'b0;
		endcase
	end

	// ------------------------------------------------------------
	// Response register
	// ------------------------------------------------------------
	// Answer one cycle after the strobe; data holds until the next read
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			rsp_valid <= 1'b0;
			rsp_data <= WORD_RESET;
			rsp_hit <= 1'b0;
		end else begin
			rsp_valid <= rd;
			rsp_hit <= rd & rd_hit;
			// Word bits 7:0 go out first on the bus
			if (rd) begin
				rsp_data <= rd_word;
			end
		end
	end
endmodule

// ===== rtl/pst_pkg.sv
// Package: command codes, field positions and reset values of the bank
package pst_pkg;
	localparam logic [7:0] CMD_OTHER_STATUS = 8'h7F;
	localparam logic [7:0] CMD_VENDOR_STATUS = 8'h80;
	localparam logic [7:0] CMD_VIN = 8'h88;
	localparam logic [7:0] CMD_IIN = 8'h89;
	localparam logic [7:0] CMD_VOUT = 8'h8B;
	localparam logic [7:0] CMD_IOUT = 8'h8C;
	localparam logic [7:0] CMD_TEMP1 = 8'h8D;
	localparam logic [7:0] CMD_TEMP2 = 8'h8E;
	localparam logic [7:0] PAGE_A = 8'h00;
	localparam logic [7:0] PAGE_B = 8'h01;
	localparam logic [7:0] PAGE_ALL = 8'hFF;
	localparam logic [7:0] PHASE_ALL = 8'hFF;
	localparam int FIRST_ALERTER_BIT = 0;
	localparam int SELFCHECK_BIT = 7;
	localparam int EXT_INFO_BIT = 6;
	localparam int SETTLED_BIT = 5;
	localparam int PHASE_ERR_BIT = 4;
	localparam int RESET_PIN_BIT = 3;
	localparam int STAGE_FAULT_BIT = 0;
	localparam logic [7:0] OTHER_MASK = 8'h01;
	localparam logic [7:0] VENDOR_MASK = 8'hF9;
	localparam int SUM_OTHER_BIT = 0;
	localparam int SUM_VENDOR_BIT = 1;
	localparam int SUM_CML_BIT = 2;
	localparam int OTHER_COMM_FAULT_FLAG_BIT = 0;
	localparam logic [7:0] STATUS_RESET = 8'h00;
	localparam logic [15:0] WORD_RESET = 16'h0000;
	localparam int PHASE_NUM = 8;
	localparam logic [15:0] GAIN_UNITY = 16'h0100;
	localparam int GAIN_SHIFT = 8;
endpackage

// ===== verif/pst_bank_checker.sv
// Concurrent checks on the status and telemetry bank ports
`timescale 1ns/100ps
module pst_bank_checker
	import pst_pkg::*;
(
	input wire logic clk,
	input wire logic rstn,
	input wire logic cmd_valid,
	input wire logic cmd_write,
	input wire logic [7:0] cmd_code,
	input wire logic [7:0] cmd_wdata,
	input wire logic alert_first_evt,
	input wire logic selfcheck_fail,
	input wire logic reset_pin_assigned,
	input wire logic reset_pin_evt,
	input wire logic [1:0] stage_fault_indication,
	input wire logic rsp_valid,
	input wire logic [7:0] other_status_byte,
	input wire logic [7:0] vendor_status_a,
	input wire logic [7:0] vendor_status_b,
	input wire logic [7:0] summary_a,
	input wire logic [7:0] summary_b,
	input wire logic other_comm_fault_flag,
	input wire logic latched_off
);
	default clocking @(posedge clk); endclocking
	default disable iff (!rstn);
	wire wr_any = cmd_valid && cmd_write;
	wire rd_any = cmd_valid && !cmd_write;
	wire ro_wr = wr_any && cmd_code inside {CMD_VIN, CMD_IIN, CMD_VOUT,
		CMD_IOUT, CMD_TEMP1, CMD_TEMP2};
	wire oth_clr = wr_any && cmd_code == CMD_OTHER_STATUS && cmd_wdata[0];
	a_first_alert_latch: assert property (alert_first_evt |=>
		other_status_byte == 8'h01) else $error("first alert not latched");
	a_summary_both_pages: assert property (summary_a[0] ==
		other_status_byte[0] && summary_b[0] == other_status_byte[0])
		else $error("summary copies differ from shared byte");
	a_shared_clear_sum: assert property (oth_clr && !alert_first_evt
		|=> !summary_a[0] && !summary_b[0] && !other_status_byte[0])
		else $error("shared clear left summary bit");
	a_selfcheck_latch: assert property (selfcheck_fail |=>
		vendor_status_a[7] && vendor_status_b[7] && latched_off)
		else $error("self check failure not latched");
	a_latch_off_sticky: assert property (latched_off |=>
		latched_off[*3]) else $error("latched off released");
	a_reset_pin_gate: assert property (reset_pin_evt &&
		!reset_pin_assigned && !vendor_status_a[3] |=> !vendor_status_a[3])
		else $error("reset pin bit set while unassigned");
	a_vendor_reserved: assert property (vendor_status_a[2:1] == 2'b00 &&
		vendor_status_b[2:1] == 2'b00) else $error("reserved bits set");
	a_read_answer: assert property (rsp_valid ==
		$past(rd_any)) else $error("read answer timing");
	a_ro_write_fault: assert property (ro_wr |=>
		other_comm_fault_flag && summary_a[2] && summary_b[2])
		else $error("read only write not flagged");
	a_stage_fault_b: assert property (stage_fault_indication[1] |=>
		vendor_status_b[0]) else $error("stage fault not latched");
endmodule
bind pst_bank pst_bank_checker pst_bank_checker_inst (.*);

// ===== verif/pst_bank_tb.sv
// Self-checking bench for the status and telemetry bank
`timescale 1ns/100ps
module pst_bank_tb;
	import pst_pkg::*;
	logic clk, rstn, cmd_valid, cmd_write, clear_all_faults_cmd;
	logic rsp_valid, rsp_hit, alert_first_evt, selfcheck_fail;
	logic reset_pin_assigned, reset_pin_evt, alert_mask_cml;
	logic sample_strobe, calculated_input_current_select;
	logic other_comm_fault_flag, latched_off, alert_out;
	logic [1:0] extended_info_evt, output_settled_evt, phase_error_evt;
	logic [1:0] stage_fault_indication;
	logic [7:0] cmd_code, cmd_wdata, page_sel, phase_sel, alert_mask_other;
	logic [7:0] alert_mask_vendor, other_status_byte, summary_a, summary_b;
	logic [7:0] vendor_status_a, vendor_status_b;
	logic [15:0] rsp_data, vin_sample, iin_sample, iin_calc_base;
	logic [15:0] calibration_gain_config, vout_a_sample, vout_b_sample;
	logic [15:0] iout_a_total, iout_b_total;
	logic [15:0] chan_a_temp_sense, chan_b_temp_sense;
	logic [PHASE_NUM*16-1:0] stage_current;
	logic [PHASE_NUM*3-1:0] phase_stage_map;
	int err_count, n_tests;
	logic [17:0] q;
	logic [7:0] pg [3] = '{8'h00, 8'hff, 8'h01};
	logic [7:0] ro [6] = '{CMD_VIN, CMD_IIN, CMD_VOUT, CMD_IOUT, CMD_TEMP1,
		CMD_TEMP2};
	pst_bank pst_bank_inst (.*);
	pst_host pst_host_inst (.*);
	initial begin
		clk = 1'b0;
		forever #2 clk = ~clk;
	end
	task automatic chk(input logic [23:0] s, input logic [23:0] e);
		n_tests++;
		if (s !== e) begin
			err_count++;
			$display("unexpected at %0t seen %h expected %h", $time, s, e);
		end
	endtask
	task automatic tick(input int n);
		repeat (n) @(negedge clk);
	endtask
	task automatic rd(input logic [7:0] c, input logic [15:0] e,
		input logic h = 1'b1);
		pst_host_inst.xfer(1'b0, c, 8'h00, q);
		chk({6'h00, q}, {7'h01, h, e});
	endtask
	task automatic wr(input logic [7:0] c, input logic [7:0] d);
		pst_host_inst.xfer(1'b1, c, d, q);
	endtask
	task automatic clr();
		clear_all_faults_cmd = 1'b1;
		tick(1);
		clear_all_faults_cmd = 1'b0;
	endtask
	task automatic complete_run();
		$display("checks %0d mismatches %0d", n_tests, err_count);
		if (err_count == 0 && n_tests > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask
	initial begin
		#200000;
		err_count++;
		complete_run();
	end
	initial begin
		rstn = 1'b0;
		{clear_all_faults_cmd, alert_first_evt, selfcheck_fail} = '0;
		{reset_pin_evt, sample_strobe, alert_mask_cml, reset_pin_assigned} = '0;
		{extended_info_evt, output_settled_evt, phase_error_evt} = '0;
		{stage_fault_indication, calculated_input_current_select} = '0;
		{alert_mask_other, alert_mask_vendor, phase_sel} = {16'h0000, PHASE_ALL};
		{page_sel, vin_sample, iin_sample} = {PAGE_A, 16'hd123, 16'he045};
		{iin_calc_base, calibration_gain_config} = {16'hf010, 16'h0200};
		{vout_a_sample, vout_b_sample} = {16'h0c00, 16'h0a00};
		{iout_a_total, iout_b_total} = {16'he820, 16'he830};
		{chan_a_temp_sense, chan_b_temp_sense} = {16'h0032, 16'h0041};
		for (int k = 0; k < PHASE_NUM; k++) begin
			stage_current[16*k +: 16] = 16'h1000 + 16'(k);
			phase_stage_map[3*k +: 3] = 3'(PHASE_NUM - 1 - k);
		end
		tick(12);
		rstn = 1'b1;
		rd(CMD_OTHER_STATUS, 16'h0000);
		rd(CMD_VENDOR_STATUS, 16'h0000);
		sample_strobe = 1'b1;
		tick(1);
		sample_strobe = 1'b0;
		rd(CMD_VIN, 16'hd123);
		rd(CMD_IIN, 16'he045);
		for (int i = 0; i < 3; i++) begin
			page_sel = pg[i];
			rd(CMD_VOUT, i == 2 ? 16'h0a00 : 16'h0c00);
			rd(CMD_IOUT, i == 2 ? 16'he830 : 16'he820);
			rd(CMD_TEMP1, i == 2 ? 16'h0041 : 16'h0032);
			rd(CMD_TEMP2, i == 2 ? 16'h0041 : 16'h0032);
		end
		phase_sel = 8'h02;
		rd(CMD_IOUT, 16'h1005);
		phase_sel = 8'h09;
		rd(CMD_IOUT, 16'h0000);
		{phase_sel, calculated_input_current_select, sample_strobe} = {PHASE_ALL, 2'b11};
		tick(1);
		sample_strobe = 1'b0;
		rd(CMD_IIN, 16'hf020);
		rd(8'h90, 16'h0000, 1'b0);
		$display("test telemetry done");
		for (int i = 0; i < 2; i++) begin
			alert_mask_other = 8'(i);
			alert_first_evt = 1'b1;
			tick(1);
			alert_first_evt = 1'b0;
			rd(CMD_OTHER_STATUS, 16'h0001);
			chk({summary_a[0], summary_b[0], alert_out}, 3'b110 | 3'(1 - i));
			wr(CMD_OTHER_STATUS, 8'h01);
			chk({other_status_byte, summary_a, summary_b}, 24'h00_0000);
		end
		$display("test shared status done");
		page_sel = PAGE_B;
		{output_settled_evt, phase_error_evt} = 4'b1010;
		{extended_info_evt, stage_fault_indication} = 4'b0110;
		tick(1);
		{output_settled_evt, phase_error_evt, extended_info_evt} = '0;
		stage_fault_indication = 2'b00;
		rd(CMD_VENDOR_STATUS, 16'h0031);
		page_sel = PAGE_A;
		rd(CMD_VENDOR_STATUS, 16'h0040);
		chk(summary_a[SUM_VENDOR_BIT], 1'b1);
		page_sel = PAGE_B;
		wr(CMD_VENDOR_STATUS, 8'h20);
		chk({vendor_status_a, vendor_status_b}, 24'h00_4011);
		clr();
		chk({vendor_status_a, vendor_status_b}, 24'h00_0000);
		for (int i = 0; i < 2; i++) begin
			{reset_pin_assigned, reset_pin_evt} = {1'(i), 1'b1};
			tick(1);
			reset_pin_evt = 1'b0;
			chk({vendor_status_a, vendor_status_b}, i ? 24'h00_0808 : 24'h0);
		end
		page_sel = PAGE_ALL;
		wr(CMD_VENDOR_STATUS, 8'h08);
		chk({vendor_status_a, vendor_status_b}, 24'h00_0000);
		clr();
		$display("test vendor status done");
		foreach (ro[i]) begin
			wr(ro[i], 8'h55);
			chk({other_comm_fault_flag, summary_a[2], summary_b[2]}, 3'b111);
			tick(1);
			chk(alert_out, 1'b1);
			clr();
		end
		alert_mask_cml = 1'b1;
		wr(CMD_VOUT, 8'h01);
		tick(1);
		chk({other_comm_fault_flag, alert_out}, 2'b10);
		$display("test read only writes done");
		selfcheck_fail = 1'b1;
		tick(1);
		selfcheck_fail = 1'b0;
		chk({latched_off, vendor_status_a[7], vendor_status_b[7]}, 3'b111);
		chk(alert_out, 1'b1);
		alert_mask_vendor = 8'h80;
		tick(1);
		chk(alert_out, 1'b0);
		clr();
		chk(latched_off, 1'b1);
		$display("test self check done");
		complete_run();
	end
endmodule

// ===== verif/pst_host.sv
// Host model issuing commands on the bank's command port
`timescale 1ns/100ps
module pst_host (
	input wire logic clk,
	output logic cmd_valid,
	output logic cmd_write,
	output logic [7:0] cmd_code,
	output logic [7:0] cmd_wdata,
	input wire logic rsp_valid,
	input wire logic rsp_hit,
	input wire logic [15:0] rsp_data
);
	initial begin
		{cmd_valid, cmd_write, cmd_code, cmd_wdata} = '0;
	end
	task automatic xfer(input logic w, input logic [7:0] c,
		input logic [7:0] d, output logic [17:0] q);
		@(negedge clk);
		{cmd_valid, cmd_write, cmd_code, cmd_wdata} = {1'b1, w, c, d};
		@(negedge clk);
		// Released lines inverted so stale values never pass
		{cmd_valid, cmd_code, cmd_wdata} = {1'b0, ~c, ~d};
		q = {rsp_valid, rsp_hit, rsp_data};
	endtask
endmodule
